// >>> hw/dcs_regs.vh
// Constants for the debug configuration and status register block.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef DCS_REGS_VH
`define DCS_REGS_VH

// ----------------------------------------------------------------
// Register selectors
// ----------------------------------------------------------------
`define DCS_SEL_CONFIG_STATUS 5'h00
`define DCS_SEL_TRIGGER_DEF 5'h07

// ----------------------------------------------------------------
// Field positions of debug_config_status
// ----------------------------------------------------------------
`define DCS_BREAKPOINT_STATE_HI 31
`define DCS_BREAKPOINT_STATE_LO 28
`define DCS_FOF_BIT 27
`define DCS_TRG_BIT 26
`define DCS_HALT_BIT 25
`define DCS_BREAKPOINT_PIN_BIT 24
`define DCS_REV_HI 23
`define DCS_REV_LO 20
`define DCS_BKD_BIT 18
`define DCS_VBD_BIT 17
`define DCS_IPW_BIT 16
`define DCS_LOW_MASK 15'h5f7f
`define DCS_LOW_RESET 15'h0000

// ----------------------------------------------------------------
// Breakpoint state encodings
// ----------------------------------------------------------------
`define DCS_BS_NONE 4'h0
`define DCS_BS_WAIT_L1 4'h1
`define DCS_BS_L1_HIT 4'h2
`define DCS_BS_WAIT_L2 4'h5
`define DCS_BS_L2_HIT 4'h6

// ----------------------------------------------------------------
// Trace buffer marking
// ----------------------------------------------------------------
`define DCS_TRACE_MARK 8'h1b
`define DCS_TRACE_BASE 8'h20

`endif

// >>> hw/dcs_breakpoint_state.v
// Breakpoint sequencing state for the debug status register.
// Assumes trigger logic gives one-cycle arm and hit pulses.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.vh"

module dcs_breakpoint_state (
  input wire clock_i,
  input wire rstn_i,
  input wire tdr_write_i,
  input wire arm_i,
  input wire l2_enable_i,
  input wire l1_hit_i,
  input wire l2_hit_i,
  input wire status_read_i,
  output reg [3:0] state_o
);
  reg [3:0] next_state;

  always @* begin
    next_state = state_o;
    case (state_o)
      `DCS_BS_NONE: if (arm_i) next_state = `DCS_BS_WAIT_L1;
      `DCS_BS_WAIT_L1: if (l1_hit_i) next_state = l2_enable_i ? `DCS_BS_WAIT_L2 : `DCS_BS_L1_HIT;
      `DCS_BS_WAIT_L2: if (l2_hit_i) next_state = `DCS_BS_L2_HIT;
      `DCS_BS_L1_HIT: if (status_read_i && !l2_enable_i) next_state = `DCS_BS_NONE;
      `DCS_BS_L2_HIT: if (status_read_i) next_state = `DCS_BS_NONE;
      default: next_state = `DCS_BS_NONE;
    endcase
    if (tdr_write_i) begin
      next_state = `DCS_BS_NONE;
    end
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_o <= `DCS_BS_NONE;
    end else begin
      state_o <= next_state;
    end
  end
endmodule // dcs_breakpoint_state
`default_nettype wire

// >>> hw/dcs_irq.v
// Debug interrupt posting with no nesting.
// Assumes one sample point pulse per instruction and a done pulse at service end.
`timescale 1ns/1ps
`default_nettype none

module dcs_irq (
  input wire clock_i,
  input wire rstn_i,
  input wire post_i,
  input wire sample_point_i,
  input wire done_i,
  output reg take_o,
  output reg pending_o,
  output reg in_service_o
);
  wire take_now;

  assign take_now = pending_o && sample_point_i && !in_service_o;

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_o <= 1'b0;
      pending_o <= 1'b0;
      in_service_o <= 1'b0;
    end else begin
      take_o <= take_now;
      // A post in the take cycle stays pending rather than being lost.
      if (post_i) begin
        pending_o <= 1'b1;
      end else if (take_now) begin
        pending_o <= 1'b0;
      end
      if (take_now) begin
        in_service_o <= 1'b1;
      end else if (done_i) begin
        in_service_o <= 1'b0;
      end
    end
  end
endmodule // dcs_irq
`default_nettype wire

// >>> hw/dcs_top.v
// Debug configuration and status register with halt reasons,
// breakpoint sequencing state, interrupt redirection and trace gating.
// Assumes all inputs are synchronous to clock_i; the serial protocol is
// decoded outside and arrives as one-cycle command strobes.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.vh"

// Notes on behaviour
// - CPU writes; host reads and writes selector zero
// - CPU side has no read path
// - Breakpoint state read-only, cleared by trigger write
// - Host read clears finished breakpoint sequence (L1 hit only with L2 off)
// - Breakpoint state uses five fixed encodings
// - Trace mark followed by doubled state record
// - Fault-on-fault flag cleared by reset, read
// - Trigger flag cleared by reset, resume, read
// - Halt flag cleared by reset, resume, read
// - Breakpoint flag from pin, command, trace-full
// - Fixed revision code readable from host only
// - Redirect bit turns pin or command halt into interrupt
// - Falling edge or command posts interrupt
// - No nested debug interrupts
// - Trace pins quiet, breakpoint pin disconnected
// - Lock bit blocks CPU debug writes
module dcs_top #(
  parameter [3:0] REV_CODE = 4'h2 // Arbitrary revision value.
) (
  input wire clock_i,
  input wire rstn_i,
  input wire host_rd_i,
  input wire host_wr_i,
  input wire [4:0] host_sel_i,
  input wire [31:0] host_wdata_i,
  input wire cpu_wr_i,
  input wire [4:0] cpu_sel_i,
  input wire [31:0] cpu_wdata_i,
  input wire resume_cmd_i,
  input wire background_cmd_i,
  input wire breakpoint_pin_i,
  input wire fault_halt_i,
  input wire hw_trigger_halt_i,
  input wire halt_insn_i,
  input wire trace_full_halt_i,
  input wire trig_arm_i,
  input wire trig_l2_enable_i,
  input wire trig_l1_hit_i,
  input wire trig_l2_hit_i,
  input wire sample_point_i,
  input wire irq_done_i,
  input wire trace_valid_i,
  input wire [7:0] trace_entry_i,
  input wire trace_clock_i,
  input wire [3:0] processor_status_i,
  input wire [3:0] debug_data_i,
  output reg [31:0] host_rdata_o,
  output reg host_rvalid_o,
  output reg dreg_wr_o,
  output reg [4:0] dreg_sel_o,
  output reg [31:0] dreg_wdata_o,
  output reg debug_halt_o,
  output reg debug_irq_o,
  output reg trace_rec_valid_o,
  output reg [7:0] trace_rec_o,
  output reg trace_clock_o,
  output reg [3:0] processor_status_lines_o,
  output reg [3:0] debug_data_lines_o,
  output reg trace_pins_en_o,
  output reg [14:0] config_low_o,
  output reg breakpoint_to_interrupt_o,
  output reg trace_pins_disable_o,
  output reg cpu_write_lock_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg fault_on_fault_flag;
  reg hw_trigger_flag;
  reg halt_flag;
  reg breakpoint_flag;
  reg pin_prev;
  reg mark_seen;
  wire [3:0] breakpoint_state;
  wire irq_take;
  wire irq_pending;
  wire irq_in_service;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire host_csr_rd;
  wire host_csr_wr;
  wire cpu_ok;
  wire cpu_csr_wr;
  wire tdr_write;
  wire pin_fall;
  wire pin_event;
  wire breakpoint_pin_event;
  wire halt_req;
  wire post_irq;
  wire [31:0] csr_value;

  // No CPU read port exists at all, so CPU reads cannot reach the status.
  assign host_csr_rd = host_rd_i && host_sel_i == `DCS_SEL_CONFIG_STATUS;
  assign host_csr_wr = host_wr_i && host_sel_i == `DCS_SEL_CONFIG_STATUS;
  assign cpu_ok = cpu_wr_i && !cpu_write_lock_o;
  assign cpu_csr_wr = cpu_ok && cpu_sel_i == `DCS_SEL_CONFIG_STATUS;
  assign tdr_write = (host_wr_i && host_sel_i == `DCS_SEL_TRIGGER_DEF) ||
                     (cpu_ok && cpu_sel_i == `DCS_SEL_TRIGGER_DEF);

  // The pin is ignored entirely while the trace pins are disabled.
  assign pin_fall = pin_prev && !breakpoint_pin_i && !trace_pins_disable_o;
  assign pin_event = pin_fall || background_cmd_i;
  assign breakpoint_pin_event = (pin_event && !breakpoint_to_interrupt_o) || trace_full_halt_i;
  assign post_irq = pin_event && breakpoint_to_interrupt_o;
  assign halt_req = fault_halt_i || hw_trigger_halt_i || halt_insn_i || breakpoint_pin_event;

  // ----------------------------------------------------------------
  // Read image
  // ----------------------------------------------------------------
  // Reserved positions 19 and 15 always read zero whatever was written.
  assign csr_value = {breakpoint_state, fault_on_fault_flag, hw_trigger_flag, halt_flag,
                      breakpoint_flag, REV_CODE, 1'b0, breakpoint_to_interrupt_o,
                      trace_pins_disable_o, cpu_write_lock_o, 1'b0, config_low_o};

  // ----------------------------------------------------------------
  // Breakpoint sequencing and interrupt posting
  // ----------------------------------------------------------------
  dcs_breakpoint_state u_breakpoint_state (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tdr_write_i(tdr_write),
    .arm_i(trig_arm_i),
    .l2_enable_i(trig_l2_enable_i),
    .l1_hit_i(trig_l1_hit_i),
    .l2_hit_i(trig_l2_hit_i),
    .status_read_i(host_csr_rd),
    .state_o(breakpoint_state)
  );

  dcs_irq u_irq (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .post_i(post_irq),
    .sample_point_i(sample_point_i),
    .done_i(irq_done_i),
    .take_o(irq_take),
    .pending_o(irq_pending),
    .in_service_o(irq_in_service)
  );

  // ----------------------------------------------------------------
  // Host read port
  // ----------------------------------------------------------------
  // Unknown selectors answer with zero so the host always gets a reply.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_rdata_o <= 32'h0000_0000;
      host_rvalid_o <= 1'b0;
    end else begin
      host_rvalid_o <= host_rd_i;
      if (host_csr_rd) begin
        host_rdata_o <= csr_value;
      end else if (host_rd_i) begin
        host_rdata_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Halt reason flags
  // ----------------------------------------------------------------
  // A new event in the clearing cycle wins, so no halt reason is lost.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_on_fault_flag <= 1'b0;
      hw_trigger_flag <= 1'b0;
      halt_flag <= 1'b0;
      breakpoint_flag <= 1'b0;
    end else begin
      if (fault_halt_i) begin
        fault_on_fault_flag <= 1'b1;
      end else if (host_csr_rd) begin
        fault_on_fault_flag <= 1'b0;
      end
      if (hw_trigger_halt_i) begin
        hw_trigger_flag <= 1'b1;
      end else if (host_csr_rd || resume_cmd_i) begin
        hw_trigger_flag <= 1'b0;
      end
      if (halt_insn_i) begin
        halt_flag <= 1'b1;
      end else if (host_csr_rd || resume_cmd_i) begin
        halt_flag <= 1'b0;
      end
      if (breakpoint_pin_event) begin
        breakpoint_flag <= 1'b1;
      end else if (host_csr_rd || resume_cmd_i) begin
        breakpoint_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // Host writes take priority over a CPU write in the same cycle.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      breakpoint_to_interrupt_o <= 1'b0;
      trace_pins_disable_o <= 1'b0;
      cpu_write_lock_o <= 1'b0;
      config_low_o <= `DCS_LOW_RESET;
    end else if (host_csr_wr) begin
      breakpoint_to_interrupt_o <= host_wdata_i[`DCS_BKD_BIT];
      trace_pins_disable_o <= host_wdata_i[`DCS_VBD_BIT];
      cpu_write_lock_o <= host_wdata_i[`DCS_IPW_BIT];
      config_low_o <= host_wdata_i[14:0] & `DCS_LOW_MASK;
    end else if (cpu_csr_wr) begin
      breakpoint_to_interrupt_o <= cpu_wdata_i[`DCS_BKD_BIT];
      trace_pins_disable_o <= cpu_wdata_i[`DCS_VBD_BIT];
      config_low_o <= cpu_wdata_i[14:0] & `DCS_LOW_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Forwarding of writes to the other debug registers
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dreg_wr_o <= 1'b0;
      dreg_sel_o <= 5'h00;
      dreg_wdata_o <= 32'h0000_0000;
    end else begin
      dreg_wr_o <= host_wr_i || cpu_ok;
      if (host_wr_i) begin
        dreg_sel_o <= host_sel_i;
        dreg_wdata_o <= host_wdata_i;
      end else if (cpu_ok) begin
        dreg_sel_o <= cpu_sel_i;
        dreg_wdata_o <= cpu_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Halt and interrupt requests
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_prev <= 1'b1;
      debug_halt_o <= 1'b0;
      debug_irq_o <= 1'b0;
    end else begin
      pin_prev <= breakpoint_pin_i;
      debug_halt_o <= halt_req;
      debug_irq_o <= irq_take;
    end
  end

  // ----------------------------------------------------------------
  // Trace path
  // ----------------------------------------------------------------
  // The record after the mark entry doubles the state into the low bits.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mark_seen <= 1'b0;
      trace_rec_valid_o <= 1'b0;
      trace_rec_o <= 8'h00;
    end else begin
      trace_rec_valid_o <= trace_valid_i || mark_seen;
      if (mark_seen) begin
        trace_rec_o <= `DCS_TRACE_BASE + {3'b000, breakpoint_state, 1'b0};
        mark_seen <= 1'b0;
      end else if (trace_valid_i) begin
        trace_rec_o <= trace_entry_i;
        mark_seen <= trace_entry_i == `DCS_TRACE_MARK;
      end
    end
  end

  // While the mark record is being inserted and the trace pins are enabled, the status lines show the doubled state.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trace_clock_o <= 1'b0;
      processor_status_lines_o <= 4'h0;
      debug_data_lines_o <= 4'h0;
      trace_pins_en_o <= 1'b1;
    end else if (trace_pins_disable_o) begin
      trace_clock_o <= 1'b0;
      processor_status_lines_o <= 4'h0;
      debug_data_lines_o <= 4'h0;
      trace_pins_en_o <= 1'b0;
    end else begin
      trace_clock_o <= trace_clock_i;
      processor_status_lines_o <= mark_seen ? {breakpoint_state[2:0], 1'b0} : processor_status_i;
      debug_data_lines_o <= debug_data_i;
      trace_pins_en_o <= 1'b1;
    end
  end

endmodule // dcs_top
`default_nettype wire

// >>> tb/dcs_checker.sv
// Checker for the debug configuration and status register block.
// Assumes one clock domain; bound to every dcs_top instance.
`timescale 1ns/1ps
`default_nettype none
module dcs_checker #(
  parameter logic [3:0] REV_CODE = 4'h2
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [4:0] host_sel_i,
  input wire logic cpu_wr_i,
  input wire logic background_cmd_i,
  input wire logic fault_halt_i,
  input wire logic irq_done_i,
  input wire logic trace_valid_i,
  input wire logic [7:0] trace_entry_i,
  input wire logic trace_clock_i,
  input wire logic [3:0] debug_data_i,
  input wire logic [31:0] host_rdata_o,
  input wire logic host_rvalid_o,
  input wire logic dreg_wr_o,
  input wire logic debug_halt_o,
  input wire logic debug_irq_o,
  input wire logic trace_rec_valid_o,
  input wire logic [7:0] trace_rec_o,
  input wire logic trace_clock_o,
  input wire logic [3:0] processor_status_lines_o,
  input wire logic [3:0] debug_data_lines_o,
  input wire logic trace_pins_en_o,
  input wire logic breakpoint_to_interrupt_o,
  input wire logic trace_pins_disable_o,
  input wire logic cpu_write_lock_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  sequence status_rd;
    host_rd_i && host_sel_i == 5'h00;
  endsequence
  // The record after the mark must match the doubled state on the status lines.
  sequence mark_then_record;
    trace_rec_valid_o && trace_rec_o == 8'h1b ##1 trace_rec_valid_o && trace_rec_o[7:4] == 4'h2
      && trace_rec_o[3:0] == processor_status_lines_o;
  endsequence
  a_read_answer: assert property (host_rd_i |=> host_rvalid_o) else $error("read not answered");
  a_cpu_no_read: assert property (cpu_wr_i && !host_rd_i |=> !host_rvalid_o) else $error("cpu write answered");
  a_rev_field: assert property (status_rd |=> host_rdata_o[23:20] == REV_CODE
    && !host_rdata_o[19] && !host_rdata_o[15]) else $error("revision or reserved bits wrong");
  a_fault_read_clear: assert property ((host_rd_i && host_sel_i == 5'h00 && !fault_halt_i) ##1 status_rd
    |=> !host_rdata_o[27]) else $error("fault flag survived a read");
  a_lock_refuse: assert property (cpu_wr_i && cpu_write_lock_o && !host_wr_i |=> !dreg_wr_o)
    else $error("locked cpu write accepted");
  a_lock_cpu_stable: assert property (cpu_wr_i && !host_wr_i |=> $stable(cpu_write_lock_o))
    else $error("cpu changed the lock");
  a_trace_mark: assert property (trace_valid_i && trace_entry_i == 8'h1b && !trace_pins_disable_o
    |=> mark_then_record) else $error("trace record wrong");
  a_pins_quiet: assert property (trace_pins_disable_o |=> !trace_pins_en_o && !trace_clock_o
    && processor_status_lines_o == 4'h0 && debug_data_lines_o == 4'h0) else $error("trace pins active");
  a_data_pass: assert property (!trace_pins_disable_o |=> debug_data_lines_o == $past(debug_data_i)
    && trace_clock_o == $past(trace_clock_i)) else $error("trace data not passed through");
  a_bg_halt: assert property (!breakpoint_to_interrupt_o && background_cmd_i |=> debug_halt_o)
    else $error("no halt on background");
  a_irq_no_nest: assert property (debug_irq_o && !irq_done_i ##1 !irq_done_i |=> !debug_irq_o)
    else $error("nested debug interrupt");
endmodule // dcs_checker
bind dcs_top dcs_checker #(.REV_CODE(REV_CODE)) i_dcs_checker (.*);
`default_nettype wire

// >>> tb/dcs_host_model.sv
// Debug host model issuing register read and write commands.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
  input wire logic clock_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic rd_o,
  output logic wr_o,
  output logic [4:0] sel_o,
  output logic [31:0] wdata_o
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    sel_o = 5'h1f;
    wdata_o = 32'h0000_0000;
  end
  // Released lines carry inverted values so stale data cannot pass.
  task automatic write(input logic [4:0] sel, input logic [31:0] data);
    wr_o <= 1'b1;
    sel_o <= sel;
    wdata_o <= data & 32'hfff7_7fff;
    @(posedge clock_i);
    wr_o <= 1'b0;
    sel_o <= ~sel;
    wdata_o <= ~data;
    @(posedge clock_i);
  endtask
  // With n of 2 the reads go back to back; a missing answer shows as unknown.
  task automatic read(input logic [4:0] sel, input int n, output logic [31:0] d1, output logic [31:0] d2);
    rd_o <= 1'b1;
    sel_o <= sel;
    @(posedge clock_i);
    if (n == 1) rd_o <= 1'b0;
    @(posedge clock_i);
    d1 = (rvalid_i === 1'b1) ? rdata_i : 32'hxxxx_xxxx;
    rd_o <= 1'b0;
    sel_o <= ~sel;
    @(posedge clock_i);
    d2 = (rvalid_i === 1'b1 || n == 1) ? rdata_i : 32'hxxxx_xxxx;
  endtask
endmodule // dcs_host_model
`default_nettype wire

// >>> tb/dcs_top_tb.sv
// Testbench for the debug configuration and status register block.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module dcs_top_tb;
  localparam logic [3:0] REV = 4'h3; // Arbitrary revision value.
  localparam int E_RES = 5, E_ARM = 6, E_L1 = 7, E_L2 = 8, E_SMP = 9, E_DONE = 10, E_TRV = 11;
  logic clock_i, rstn_i, cpu_wr_i, breakpoint_pin_i, trig_l2_enable_i;
  logic [4:0] cpu_sel_i;
  logic [31:0] cpu_wdata_i, d1, d2;
  logic [7:0] trace_entry_i, last_rec;
  logic [11:0] ev;
  logic [8:0] raw;
  int n_fail, n_tests, n_halt, n_irq;
  wire logic host_rd_i, host_wr_i, trace_clock_i;
  wire logic [4:0] host_sel_i, dreg_sel_o;
  wire logic [31:0] host_wdata_i, host_rdata_o, dreg_wdata_o;
  wire logic fault_halt_i, hw_trigger_halt_i, halt_insn_i, trace_full_halt_i, background_cmd_i, resume_cmd_i;
  wire logic trig_arm_i, trig_l1_hit_i, trig_l2_hit_i, sample_point_i, irq_done_i, trace_valid_i;
  wire logic [3:0] processor_status_i, debug_data_i, processor_status_lines_o, debug_data_lines_o;
  wire logic host_rvalid_o, dreg_wr_o, debug_halt_o, debug_irq_o, trace_rec_valid_o, trace_clock_o;
  wire logic trace_pins_en_o, breakpoint_to_interrupt_o, trace_pins_disable_o, cpu_write_lock_o;
  wire logic [7:0] trace_rec_o;
  wire logic [14:0] config_low_o;
  assign {trace_valid_i, irq_done_i, sample_point_i, trig_l2_hit_i, trig_l1_hit_i, trig_arm_i, resume_cmd_i,
    background_cmd_i, trace_full_halt_i, halt_insn_i, hw_trigger_halt_i, fault_halt_i} = ev;
  assign {trace_clock_i, processor_status_i, debug_data_i} = raw;
  dcs_top #(.REV_CODE(REV)) i_dcs_top (.*);
  dcs_host_model i_dcs_host_model (.clock_i(clock_i), .rdata_i(host_rdata_o), .rvalid_i(host_rvalid_o),
    .rd_o(host_rd_i), .wr_o(host_wr_i), .sel_o(host_sel_i), .wdata_o(host_wdata_i));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    raw <= raw + 9'h001;
    if (debug_halt_o === 1'b1) n_halt <= n_halt + 1;
    if (debug_irq_o === 1'b1) n_irq <= n_irq + 1;
    if (trace_rec_valid_o === 1'b1) last_rec <= trace_rec_o;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input int idx);
    ev[idx] <= 1'b1;
    @(posedge clock_i);
    ev <= 12'h000;
    @(posedge clock_i);
  endtask
  task automatic cpu_write(input logic [4:0] sel, input logic [31:0] data);
    cpu_wr_i <= 1'b1;
    cpu_sel_i <= sel;
    cpu_wdata_i <= data;
    @(posedge clock_i);
    cpu_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rstn_i, cpu_wr_i, trig_l2_enable_i, cpu_sel_i, cpu_wdata_i, ev, raw, trace_entry_i} = '0;
    breakpoint_pin_i = 1'b1;
    {n_fail, n_tests, n_halt, n_irq} = '0;
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    i_dcs_host_model.read(5'h00, 1, d1, d2);
    chk(d1, {8'h00, REV, 20'h0_0000});
    // Each halt cause except the pin edge sets its flag, and a status read clears it.
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      i_dcs_host_model.read(5'h00, 2, d1, d2);
      chk(d1[27:24], (i == 4) ? 4'h1 : (4'h8 >> i));
      chk(d2[27:24], 4'h0);
    end
    pulse(1);
    pulse(0);
    pulse(E_RES);
    i_dcs_host_model.read(5'h00, 1, d1, d2);
    chk(d1[27:24], 4'h8);
    i_dcs_host_model.write(5'h00, 32'hffff_ffff);
    i_dcs_host_model.read(5'h00, 1, d1, d2);
    chk(d1[19:0], 20'h7_5f7f);
    chk(config_low_o, 15'h5f7f);
    chk({trace_pins_en_o, processor_status_lines_o, debug_data_lines_o, trace_clock_o}, 10'h000);
    breakpoint_pin_i <= 1'b0;
    @(posedge clock_i);
    pulse(E_SMP);
    breakpoint_pin_i <= 1'b1;
    chk(n_irq, 0);
    cpu_write(5'h00, 32'h0000_0000);
    i_dcs_host_model.read(5'h00, 1, d1, d2);
    chk(d1[19:0], 20'h7_5f7f);
    i_dcs_host_model.write(5'h00, 32'h0000_0000);
    cpu_write(5'h00, 32'h0005_0000);
    chk({breakpoint_to_interrupt_o, trace_pins_disable_o, cpu_write_lock_o}, 3'b100);
    // Redirected pin edge is taken; a second request waits for service end.
    breakpoint_pin_i <= 1'b0;
    @(posedge clock_i);
    pulse(E_SMP);
    pulse(4);
    pulse(E_SMP);
    @(posedge clock_i);
    chk(n_irq, 1);
    pulse(E_DONE);
    pulse(E_SMP);
    // The interrupt pulse comes one edge after the sample edge and is counted one edge later.
    repeat (2) @(posedge clock_i);
    chk(n_irq, 2);
    chk(n_halt, 7);
    breakpoint_pin_i <= 1'b1;
    i_dcs_host_model.write(5'h00, 32'h0000_0000);
    pulse(E_ARM);
    i_dcs_host_model.read(5'h00, 1, d1, d2);
    chk(d1[31:28], 4'h1);
    pulse(E_L1);
    i_dcs_host_model.read(5'h00, 2, d1, d2);
    chk({d1[31:28], d2[31:28]}, 8'h20);
    trig_l2_enable_i <= 1'b1;
    pulse(E_ARM);
    pulse(E_L1);
    i_dcs_host_model.read(5'h00, 2, d1, d2);
    chk({d1[31:28], d2[31:28]}, 8'h55);
    trace_entry_i <= 8'h1b;
    pulse(E_L2);
    pulse(E_TRV);
    repeat (2) @(posedge clock_i);
    chk(last_rec, 8'h2c);
    i_dcs_host_model.read(5'h00, 2, d1, d2);
    chk({d1[31:28], d2[31:28]}, 8'h60);
    pulse(E_ARM);
    i_dcs_host_model.write(5'h07, 32'h0000_0000);
    i_dcs_host_model.read(5'h00, 1, d1, d2);
    chk(d1[31:28], 4'h0);
    pulse(E_ARM);
    cpu_write(5'h07, 32'h0000_00a5);
    chk({dreg_wr_o, dreg_sel_o}, 6'h27);
    chk(dreg_wdata_o, 32'h0000_00a5);
    i_dcs_host_model.read(5'h00, 1, d1, d2);
    chk(d1[31:28], 4'h0);
    summarize();
  end
  initial begin
    #200_000;
    n_fail++;
    summarize();
  end
endmodule // dcs_top_tb
`default_nettype wire
